// ### logic/wrc_pkg.sv
// package of constants for the watchdog and reset control block
package wrc_pkg;
  // register byte offsets on apb
  localparam logic [7:0] WRC_WATCHDOG_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] WRC_MODE1_OFS = 8'h04;
  localparam logic [7:0] WRC_PINSEL_OFS = 8'h08;
  localparam logic [7:0] WRC_STAT_OFS = 8'h0C;
  localparam logic [7:0] WRC_CMD_OFS = 8'h10;
  // watchdog control fields
  localparam int WRC_KEY_LSB = 3;
  localparam int WRC_PER_LSB = 0;
  localparam logic [4:0] WRC_KEY_DIS = 5'h15;
  localparam logic [4:0] WRC_KEY_EN = 5'h0A;
  localparam logic [7:0] WRC_WATCHDOG_CONTROL_REG_RST = 8'h53;
  localparam logic [2:0] WRC_PER_RST = 3'h3;
  // mode control reg1 fields
  localparam int WRC_KF_BIT = 0;
  localparam int WRC_UV_BIT = 2;
  // pin function select codes
  localparam logic [7:0] WRC_PIN_PORT = 8'h55;
  localparam logic [7:0] WRC_PIN_INIT = 8'hAA;
  localparam logic [7:0] WRC_PINSEL_RST = 8'h55;
  // status fields
  localparam int WRC_TO_BIT = 0;
  localparam int WRC_PD_BIT = 1;
  // command register bits
  localparam int WRC_CMD_CLR_BIT = 0;
  localparam int WRC_CMD_HALT_BIT = 1;
  localparam int WRC_CMD_WAKE_BIT = 2;
  // watchdog division base exponent
  localparam int WRC_DIV_MIN = 8;
  // timing, slow clock is 32 khz
  localparam int WRC_SLOW_HZ = 32000;
  localparam real WRC_PIN_DLY_MS = 16.7;
  localparam real WRC_POR_DLY_MS = 50.0;
  localparam int WRC_PIN_DLY_CYC =
    int'($floor(WRC_PIN_DLY_MS * WRC_SLOW_HZ / 1000.0));
  localparam int WRC_POR_DLY_CYC =
    int'($floor(WRC_POR_DLY_MS * WRC_SLOW_HZ / 1000.0));
  localparam int WRC_UVQ_CYC = 4;
  localparam int WRC_FIRE_CYC = 2;
endpackage

// ### logic/wrc_slow_dom.sv
// slow-clock watchdog counter, filters and reset timer
`timescale 1ns/1ps
`default_nettype none
module wrc_slow_dom #(
  parameter int POR_DLY = wrc_pkg::WRC_POR_DLY_CYC,
  parameter int PIN_DLY = wrc_pkg::WRC_PIN_DLY_CYC
) (
  // slow clock and reset
  input wire logic slow_clk_in,
  input wire logic rst_b_in,
  // levels from system domain, already stable
  input wire logic wdt_en_in,
  input wire logic [2:0] period_in,
  input wire logic clear_tgl_in,
  input wire logic key_bad_in,
  input wire logic low_power_in,
  input wire logic pin_is_init_in,
  // pins
  input wire logic ext_init_pin_b_in,
  input wire logic undervoltage_in,
  // results
  output logic wdt_tgl_out,
  output logic uv_tgl_out,
  output logic hold_out
);
  import wrc_pkg::*;

  typedef struct packed {
    logic [2:0] clr_s;
    logic [1:0] pin_s;
    logic [1:0] uv_s;
    logic [1:0] kb_s;
    logic [1:0] en_s;
    logic [1:0] lp_s;
    logic [1:0] pi_s;
    logic [2:0] per_a;
    logic [2:0] per_b;
    logic [2:0] per_c;
    logic [2:0] per;
    logic [15:0] wdt;
    logic [3:0] uvq;
    logic [1:0] uvf;
    logic [1:0] kbf;
    logic [21:0] hold;
    logic hold_nz;
    logic wdt_tgl;
    logic uv_tgl;
  } wrc_slow_t;

  wrc_slow_t st_ff, nxt_st;
  logic clr_evt, pin_low, uv_low, kb, ovf, fire;
  logic [15:0] term;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clr_s = {st_ff.clr_s[1:0], clear_tgl_in};
    nxt_st.pin_s = {st_ff.pin_s[0], ext_init_pin_b_in};
    nxt_st.uv_s = {st_ff.uv_s[0], undervoltage_in};
    nxt_st.kb_s = {st_ff.kb_s[0], key_bad_in};
    nxt_st.en_s = {st_ff.en_s[0], wdt_en_in};
    nxt_st.lp_s = {st_ff.lp_s[0], low_power_in};
    nxt_st.pi_s = {st_ff.pi_s[0], pin_is_init_in};
    // period bits may skew across the crossing, so the word is only
    // taken once two synchronised samples agree
    nxt_st.per_a = period_in;
    nxt_st.per_b = st_ff.per_a;
    nxt_st.per_c = st_ff.per_b;
    if (st_ff.per_b == st_ff.per_c) begin
      nxt_st.per = st_ff.per_c;
    end
    clr_evt = st_ff.clr_s[2] ^ st_ff.clr_s[1];
    pin_low = st_ff.pi_s[1] && !st_ff.pin_s[1];
    uv_low = st_ff.uv_s[1] && !st_ff.lp_s[1];
    kb = st_ff.kb_s[1];
    term = 16'((32'd1 << (WRC_DIV_MIN + int'(st_ff.per))) - 1);
    // at or past the terminal count, so a shorter period chosen while
    // the count is already high still ends in an overflow
    ovf = st_ff.en_s[1] && (st_ff.wdt >= term);
    // watchdog count, cleared by clear/halt, pin and bad key
    if (clr_evt || pin_low || kb || ovf || !st_ff.en_s[1]) begin
      nxt_st.wdt = '0;
    end else begin
      nxt_st.wdt = st_ff.wdt + 16'h0001;
    end
    if (ovf) begin
      nxt_st.wdt_tgl = ~st_ff.wdt_tgl;
    end
    // undervoltage must persist beyond the qualify time
    if (!uv_low) begin
      nxt_st.uvq = '0;
    end else if (st_ff.uvq != 4'(WRC_UVQ_CYC)) begin
      nxt_st.uvq = st_ff.uvq + 4'h1;
    end
    // fire two slow cycles after qualifying
    fire = 1'b0;
    if (!uv_low) begin
      nxt_st.uvf = '0;
    end else if (st_ff.uvq == 4'(WRC_UVQ_CYC)) begin
      if (st_ff.uvf != 2'(WRC_FIRE_CYC)) begin
        nxt_st.uvf = st_ff.uvf + 2'h1;
      end
      fire = st_ff.uvf == 2'(WRC_FIRE_CYC - 1);
    end
    if (fire) begin
      nxt_st.uv_tgl = ~st_ff.uv_tgl;
    end
    // bad key delay before the reset takes hold
    if (!kb) begin
      nxt_st.kbf = '0;
    end else if (st_ff.kbf != 2'(WRC_FIRE_CYC)) begin
      nxt_st.kbf = st_ff.kbf + 2'h1;
    end
    // start-up hold timer
    if (pin_low) begin
      nxt_st.hold = 22'(PIN_DLY);
    end else if (fire || (kb && st_ff.kbf == 2'(WRC_FIRE_CYC - 1))) begin
      nxt_st.hold = 22'(POR_DLY);
    end else if (st_ff.hold != '0) begin
      nxt_st.hold = st_ff.hold - 22'h1;
    end
    // registered so the crossing level cannot glitch while counting
    nxt_st.hold_nz = nxt_st.hold != '0;
  end

  // power-on loads the long start-up delay
  always_ff @(posedge slow_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
      st_ff.pin_s <= 2'h3;
      st_ff.hold <= 22'(POR_DLY);
      st_ff.hold_nz <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wdt_tgl_out = st_ff.wdt_tgl;
  assign uv_tgl_out = st_ff.uv_tgl;
  assign hold_out = st_ff.hold_nz;

  a_uv_short: assert property (@(posedge slow_clk_in) disable iff (!rst_b_in)
    !uv_low |=> st_ff.uvq == '0) else $error("uv filter not cleared");
  a_wdt_clear: assert property (@(posedge slow_clk_in) disable iff (!rst_b_in)
    (pin_low || kb) |=> st_ff.wdt == '0) else $error("wdt not cleared");
endmodule
`default_nettype wire

// ### logic/wrc_top.sv
// top of the watchdog and reset control block with apb registers
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - watchdog overflow resets the device unless software clears it first
// - key 10101 disables, 01010 enables, anything else resets
// - normal-mode timeout gives full reset and sets expiry flag
// - sleep/idle timeout sets expiry, resets only pc and stack pointer
// - counter cleared by bad key, pin low, clear or halt
// - only one clear instruction clears the watchdog
// - power-on reset sets program counter to zero
// - power-on reset sets port data and control registers to ones
// - pin low resets device; execution restarts at address zero
// - pin reset in normal running keeps some registers
// - start-up delay after release: 16.7 ms pin, 50 ms power-on
// - select 0x55 means port pin, 0xAA means reset input
// - every reset restores select register except watchdog timeout resets, normal-mode or warm
// - undervoltage reset active in normal, off in sleep or idle
// - undervoltage must last beyond qualify time to reset
// - reset two slow cycles after qualify, set undervoltage flag
// - bad key resets at once, start-up hold two slow cycles later, sets sticky fault flag
// - three-bit period chooses 2^8..2^15, default 011
// - sleep timeout leaves both flags set; power-on clears both
module wrc_top #(
  parameter int POR_DLY = wrc_pkg::WRC_POR_DLY_CYC,
  parameter int PIN_DLY = wrc_pkg::WRC_PIN_DLY_CYC
) (
  // system clock, reset and slow clock
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_clk_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins and comparator
  input wire logic ext_init_pin_b_in,
  input wire logic undervoltage_in,
  // core side
  output logic core_reset_out,
  output logic pc_sp_reset_out,
  output logic run_inhibit_out,
  output logic port_init_out,
  output logic port_a_bit7_is_init_out
);
  import wrc_pkg::*;

  typedef struct packed {
    logic [1:0] rs;
    logic [7:0] watchdog_control_reg;
    logic kf;
    logic uv;
    logic [7:0] pinsel;
    logic to;
    logic pd;
    logic clr_tgl;
    logic [2:0] wt_s;
    logic [2:0] ut_s;
    logic [2:0] hd_s;
    logic core_rst;
    logic pcsp;
    logic port_init;
    logic wen;
    logic kbd;
    logic a7;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } wrc_top_t;

  wrc_top_t st_ff, nxt_st;
  logic rst_sync_b;
  logic wdt_tgl, uv_tgl, hold;
  logic wdt_evt, uv_evt, acc, wr, rd, key_bad;
  logic [4:0] key;

  // ************************************************
  // reset release
  // ************************************************
  // rs is the released reset; only its second stage is used
  assign rst_sync_b = st_ff.rs[1];

  wrc_slow_dom #(
    .POR_DLY(POR_DLY),
    .PIN_DLY(PIN_DLY)
  ) u_slow (
    .slow_clk_in(slow_clk_in),
    .rst_b_in(rst_sync_b),
    .wdt_en_in(st_ff.wen),
    .period_in(st_ff.watchdog_control_reg[2:0]),
    .clear_tgl_in(st_ff.clr_tgl),
    .key_bad_in(st_ff.kbd),
    .low_power_in(st_ff.pd),
    .pin_is_init_in(st_ff.a7),
    .ext_init_pin_b_in(ext_init_pin_b_in),
    .undervoltage_in(undervoltage_in),
    .wdt_tgl_out(wdt_tgl),
    .uv_tgl_out(uv_tgl),
    .hold_out(hold)
  );

  // ************************************************
  // state update
  // ************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rs = {st_ff.rs[0], 1'b1};
    nxt_st.wt_s = {st_ff.wt_s[1:0], wdt_tgl};
    nxt_st.ut_s = {st_ff.ut_s[1:0], uv_tgl};
    nxt_st.hd_s = {st_ff.hd_s[1:0], hold};
    wdt_evt = st_ff.wt_s[2] ^ st_ff.wt_s[1];
    uv_evt = st_ff.ut_s[2] ^ st_ff.ut_s[1];
    key = st_ff.watchdog_control_reg[7:3];
    key_bad = key != WRC_KEY_EN && key != WRC_KEY_DIS;
    acc = psel_in && penable_in && !st_ff.rdy;
    wr = acc && pwrite_in;
    rd = acc && !pwrite_in;
    nxt_st.rdy = acc;
    nxt_st.err = 1'b0;
    nxt_st.pcsp = 1'b0;
    nxt_st.core_rst = st_ff.hd_s[1] || key_bad;
    nxt_st.port_init = st_ff.hd_s[1];
    // software writes
    if (wr) begin
      unique case (paddr_in)
        WRC_WATCHDOG_CONTROL_REG_OFS: nxt_st.watchdog_control_reg = pwdata_in[7:0];
        WRC_MODE1_OFS: begin
          // flags can only be cleared, never set by software
          if (!pwdata_in[WRC_KF_BIT]) begin
            nxt_st.kf = 1'b0;
          end
          if (!pwdata_in[WRC_UV_BIT]) begin
            nxt_st.uv = 1'b0;
          end
        end
        WRC_PINSEL_OFS: nxt_st.pinsel = pwdata_in[7:0];
        WRC_STAT_OFS: ;
        WRC_CMD_OFS: begin
          if (pwdata_in[WRC_CMD_CLR_BIT] || pwdata_in[WRC_CMD_HALT_BIT]) begin
            nxt_st.clr_tgl = ~st_ff.clr_tgl;
          end
          if (pwdata_in[WRC_CMD_CLR_BIT]) begin
            nxt_st.pd = 1'b0;
            nxt_st.to = 1'b0;
          end
          if (pwdata_in[WRC_CMD_HALT_BIT]) begin
            nxt_st.pd = 1'b1;
            nxt_st.to = 1'b0;
          end
          if (pwdata_in[WRC_CMD_WAKE_BIT]) begin
            nxt_st.pd = 1'b0;
          end
        end
        default: nxt_st.err = 1'b1;
      endcase
    end
    // hardware set wins over software clear
    if (key_bad && st_ff.hd_s[1]) begin
      nxt_st.kf = 1'b1;
    end
    if (uv_evt) begin
      nxt_st.uv = 1'b1;
      nxt_st.pinsel = WRC_PINSEL_RST;
    end
    if (key_bad && st_ff.hd_s[1]) begin
      // device reset restores the key once the reset is under way
      nxt_st.watchdog_control_reg = {WRC_KEY_EN, st_ff.watchdog_control_reg[2:0]};
      nxt_st.pinsel = WRC_PINSEL_RST;
    end
    if (st_ff.hd_s[2] && !st_ff.hd_s[1]) begin
      // any held reset ends with the select word back at port use;
      // key and period are kept, so a pin reset is a warm one
      nxt_st.pinsel = WRC_PINSEL_RST;
    end
    if (wdt_evt) begin
      nxt_st.to = 1'b1;
      if (st_ff.pd) begin
        nxt_st.pcsp = 1'b1;
        nxt_st.pd = 1'b1;
      end else begin
        nxt_st.core_rst = 1'b1;
      end
    end
    // registered copies: the slow domain must never see a glitch
    nxt_st.wen = nxt_st.watchdog_control_reg[7:3] == WRC_KEY_EN;
    nxt_st.kbd = key_bad;
    nxt_st.a7 = nxt_st.pinsel == WRC_PIN_INIT;
    // read data
    nxt_st.rdata = '0;
    if (rd) begin
      unique case (paddr_in)
        WRC_WATCHDOG_CONTROL_REG_OFS: nxt_st.rdata[7:0] = st_ff.watchdog_control_reg;
        WRC_MODE1_OFS: begin
          nxt_st.rdata[WRC_KF_BIT] = st_ff.kf;
          nxt_st.rdata[WRC_UV_BIT] = st_ff.uv;
        end
        WRC_PINSEL_OFS: nxt_st.rdata[7:0] = st_ff.pinsel;
        WRC_STAT_OFS: begin
          nxt_st.rdata[WRC_TO_BIT] = st_ff.to;
          nxt_st.rdata[WRC_PD_BIT] = st_ff.pd;
        end
        WRC_CMD_OFS: ;
        default: nxt_st.err = 1'b1;
      endcase
    end
  end

  // power-on values: flags clear, select at port, ports high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
      st_ff.watchdog_control_reg <= WRC_WATCHDOG_CONTROL_REG_RST;
      st_ff.pinsel <= WRC_PINSEL_RST;
      st_ff.core_rst <= 1'b1;
      st_ff.port_init <= 1'b1;
      st_ff.hd_s <= 3'h7;
      st_ff.wen <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_out = st_ff.rdata;
  assign pready_out = st_ff.rdy;
  assign pslverr_out = st_ff.err;
  assign core_reset_out = st_ff.core_rst;
  assign pc_sp_reset_out = st_ff.pcsp;
  assign run_inhibit_out = st_ff.hd_s[1];
  assign port_init_out = st_ff.port_init;
  assign port_a_bit7_is_init_out = st_ff.a7;

  a_wdt_sleep: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wdt_evt && st_ff.pd) |=> pc_sp_reset_out && st_ff.to && st_ff.pd)
    else $error("sleep timeout wrong");
  a_wdt_norm: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wdt_evt && !st_ff.pd) |=> core_reset_out && st_ff.to)
    else $error("normal timeout no reset");
  a_key_reset: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    key_bad |=> core_reset_out) else $error("bad key no reset");
  a_uv_flag: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    uv_evt |=> st_ff.uv && st_ff.pinsel == WRC_PINSEL_RST)
    else $error("uv flag not set");
  a_hold_reset: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    st_ff.hd_s[1] |=> core_reset_out && port_init_out)
    else $error("hold without reset");
  a_kf_sticky: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (st_ff.kf && !wr) |=> st_ff.kf) else $error("fault flag lost");
  a_apb_ready: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (psel_in && penable_in && !pready_out) |=> pready_out)
    else $error("apb no answer");
  a_clear_halt: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wr && paddr_in == WRC_CMD_OFS && pwdata_in[WRC_CMD_CLR_BIT]
     && !wdt_evt) |=> !st_ff.to) else $error("clear kept expiry");

  // ************************************************
  // bus, flag and crossing checks
  // ************************************************
  // the copies handed to the slow domain must track their sources
  a_err_ready: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    !pready_out |-> prdata_out == '0)
    else $error("read data outside answer");
  a_ready_pulse: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_a7_flag: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    port_a_bit7_is_init_out == (st_ff.pinsel == WRC_PIN_INIT))
    else $error("pin use flag wrong");
  a_wen_flag: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    st_ff.wen == (st_ff.watchdog_control_reg[7:3] == WRC_KEY_EN))
    else $error("enable copy wrong");
  a_kf_set: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (key_bad && st_ff.hd_s[1]) |=> st_ff.kf)
    else $error("fault flag not set");
  a_key_restore: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (key_bad && st_ff.hd_s[1]) |=> st_ff.watchdog_control_reg[7:3] == WRC_KEY_EN)
    else $error("key not restored");
  a_halt_clear: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wr && paddr_in == WRC_CMD_OFS && pwdata_in[WRC_CMD_HALT_BIT])
    |=> st_ff.clr_tgl != $past(st_ff.clr_tgl)) else $error("halt no clear");
  a_pinsel_end: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (st_ff.hd_s[2] && !st_ff.hd_s[1]) |=> st_ff.pinsel == WRC_PINSEL_RST)
    else $error("select not restored");
  a_uv_clear: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wr && paddr_in == WRC_MODE1_OFS && !pwdata_in[WRC_UV_BIT] && !uv_evt)
    |=> !st_ff.uv) else $error("uv flag not cleared");
  a_core_release: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    $fell(core_reset_out) |-> !$past(st_ff.hd_s[1]))
    else $error("core left reset early");
  a_no_core_sleep: assert property (@(posedge clk_in) disable iff (!rst_sync_b)
    (wdt_evt && st_ff.pd && !st_ff.hd_s[1] && !key_bad) |=> !core_reset_out)
    else $error("sleep timeout reset core");
endmodule
`default_nettype wire

// ### verif/wrc_far_model.sv
// far-side model: reset pin, supply comparator and core reset watcher
`timescale 1ns/1ps
`default_nettype none
module wrc_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // bench requests
  input wire logic pin_low_in,
  input wire logic uv_in,
  // device side
  input wire logic core_reset_in,
  output logic ext_init_pin_b_out,
  output logic undervoltage_out,
  output logic [7:0] n_resets_out
);
  logic rst_q_ff;
  // the pin has a pull-up, so a released pin reads high, never stale
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_init_pin_b_out <= 1'b1;
      undervoltage_out <= 1'b0;
      rst_q_ff <= 1'b1;
      n_resets_out <= 8'h00;
    end else begin
      ext_init_pin_b_out <= ~pin_low_in;
      undervoltage_out <= uv_in;
      rst_q_ff <= core_reset_in;
      // the watcher counts each entry of the core into reset it sees
      if (core_reset_in && !rst_q_ff) begin
        n_resets_out <= n_resets_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/wrc_top_bench.sv
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
module wrc_top_bench;
  import wrc_pkg::*;
  // short start-up counts keep the run brief
  localparam int DLY = 8;
  logic clk = 1'b0, slow_clk = 1'b0, rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, n_res, n0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, er, saw_inh;
  logic pin_low = 1'b0, uv = 1'b0, pin_b, uv_w;
  logic core_reset, pc_sp, run_inh, port_init, a7_init;
  int n_errors = 0, compares = 0;
  always #50 clk = ~clk;
  // slow clock unrelated in phase to the system clock
  always #515 slow_clk = ~slow_clk;
  wrc_top #(.POR_DLY(DLY), .PIN_DLY(DLY)) DUT (.clk_in(clk),
    .rst_b_in(rst_b), .slow_clk_in(slow_clk), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ext_init_pin_b_in(pin_b),
    .undervoltage_in(uv_w), .core_reset_out(core_reset),
    .pc_sp_reset_out(pc_sp), .run_inhibit_out(run_inh),
    .port_init_out(port_init), .port_a_bit7_is_init_out(a7_init));
  wrc_far_model u_far (.clk_in(clk), .rst_b_in(rst_b),
    .pin_low_in(pin_low), .uv_in(uv), .core_reset_in(core_reset),
    .ext_init_pin_b_out(pin_b), .undervoltage_out(uv_w),
    .n_resets_out(n_res));
  // ****************
  // checks and bus tasks
  // ****************
  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) fail($sformatf("got %h want %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) fail($sformatf("flag got %b want %b", g, e));
  endtask
  // holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    chk1(pready, 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32(r & m, e);
  endtask
  // waits for the core to leave reset, noting the start-up inhibit
  task automatic wait_up();
    int i;
    i = 0;
    while (core_reset !== 1'b0 && i < 4000) begin
      @(negedge clk);
      i++;
      if (run_inh === 1'b1) saw_inh = 1'b1;
    end
    chk1(core_reset, 1'b0);
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_hi();
    int i;
    i = 0;
    while (core_reset !== 1'b1 && i < 6000) begin
      @(negedge clk);
      i++;
    end
    chk1(core_reset, 1'b1);
  endtask
  task automatic print_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // ****************
  // test sequence
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    chk1(core_reset, 1'b1);
    chk1(port_init, 1'b1);
    rst_b <= 1'b1;
    wait_up();
    chk1(port_init, 1'b0);
    rd(WRC_WATCHDOG_CONTROL_REG_OFS, 32'hFF, 32'h53);
    rd(WRC_PINSEL_OFS, 32'hFF, 32'h55);
    rd(WRC_STAT_OFS, 32'h3, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk1(er, 1'b1);
    apb(1'b1, WRC_PINSEL_OFS, 32'hAA);
    chk1(a7_init, 1'b1);
    // shortest period, then no clearing: the watchdog must fire
    apb(1'b1, WRC_WATCHDOG_CONTROL_REG_OFS, 32'h50);
    wait_hi();
    wait_up();
    rd(WRC_STAT_OFS, 32'h1, 32'h1);
    rd(WRC_PINSEL_OFS, 32'hFF, 32'hAA);
    // regular clearing must keep the watchdog quiet for about three periods
    n0 = n_res;
    apb(1'b1, WRC_WATCHDOG_CONTROL_REG_OFS, 32'h50);
    repeat (8) begin
      repeat (1000) @(posedge clk);
      apb(1'b1, WRC_CMD_OFS, 32'h1);
    end
    chk1(n_res == n0, 1'b1);
    // sleep: low supply is ignored, timeout hits only pc and sp
    apb(1'b1, WRC_CMD_OFS, 32'h2);
    uv <= 1'b1;
    repeat (300) @(posedge clk);
    uv <= 1'b0;
    saw_inh = 1'b0;
    for (int i = 0; i < 5000 && saw_inh !== 1'b1; i++) begin
      @(negedge clk);
      if (pc_sp === 1'b1) saw_inh = 1'b1;
    end
    chk1(saw_inh, 1'b1);
    chk1(n_res == n0, 1'b1);
    rd(WRC_STAT_OFS, 32'h3, 32'h3);
    apb(1'b1, WRC_CMD_OFS, 32'h4);
    // a bad key resets at once and leaves the sticky fault flag
    apb(1'b1, WRC_WATCHDOG_CONTROL_REG_OFS, 32'h00);
    wait_hi();
    wait_up();
    rd(WRC_MODE1_OFS, 32'h1, 32'h1);
    rd(WRC_PINSEL_OFS, 32'hFF, 32'h55);
    apb(1'b1, WRC_MODE1_OFS, 32'h0);
    rd(WRC_MODE1_OFS, 32'h1, 32'h0);
    apb(1'b1, WRC_WATCHDOG_CONTROL_REG_OFS, 32'hAB);
    // pin reset, then the start-up inhibit after release
    apb(1'b1, WRC_PINSEL_OFS, 32'hAA);
    pin_low <= 1'b1;
    repeat (200) @(posedge clk);
    chk1(core_reset, 1'b1);
    pin_low <= 1'b0;
    saw_inh = 1'b0;
    wait_up();
    chk1(saw_inh, 1'b1);
    rd(WRC_PINSEL_OFS, 32'hFF, 32'h55);
    apb(1'b1, WRC_WATCHDOG_CONTROL_REG_OFS, 32'hAB);
    // a short dip is filtered, a long one resets and flags
    n0 = n_res;
    uv <= 1'b1;
    repeat (20) @(posedge clk);
    uv <= 1'b0;
    repeat (200) @(posedge clk);
    chk1(n_res == n0, 1'b1);
    uv <= 1'b1;
    wait_hi();
    @(posedge clk);
    uv <= 1'b0;
    wait_up();
    rd(WRC_MODE1_OFS, 32'h4, 32'h4);
    print_verdict();
  end
endmodule
`default_nettype wire
